// ### hbs_pkg.sv
package hbs_pkg;
  localparam int HBS_WAKE_W = 16;
  localparam int HBS_FUSE_BITS = 6144;
  localparam int HBS_FUSE_BYTES = HBS_FUSE_BITS / 8;
  localparam int HBS_FUSE_AW = 10;
  localparam logic [HBS_FUSE_AW-1:0] HBS_FUSE_LAST = 10'h2FF;
  localparam logic [HBS_FUSE_AW-1:0] HBS_FUSE_TRIM_ADDR = 10'h000;
  localparam logic [HBS_FUSE_AW-1:0] HBS_FUSE_PKG_ADDR = 10'h001;
  localparam logic [HBS_FUSE_AW-1:0] HBS_FUSE_MEM_ADDR = 10'h002;
  localparam logic [1:0] HBS_FIDX_TRIM = 2'h0;
  localparam logic [1:0] HBS_FIDX_PKG = 2'h1;
  localparam logic [1:0] HBS_FIDX_MEM = 2'h2;
  localparam logic [1:0] HBS_FIDX_DONE = 2'h3;
  localparam logic [7:0] HBS_BYTE_RESET = 8'h00;
  localparam logic [HBS_WAKE_W-1:0] HBS_COUNT_RESET = 16'h0000;
  localparam logic [HBS_WAKE_W-1:0] HBS_COUNT_ONE = 16'h0001;

  typedef enum logic [2:0] {
    HBS_IDLE = 3'b000,
    HBS_REG_WAIT = 3'b001,
    HBS_FUSE_INIT = 3'b010,
    HBS_CORE_UP = 3'b011,
    HBS_XTAL_WAIT = 3'b100,
    HBS_RUN = 3'b101
  } hbs_boot_t;

  typedef struct packed {
    logic [1:0] slow_s;
    logic slow_prev;
    logic [1:0] regen_s;
    logic [1:0] wake_s;
    logic [1:0] creg_s;
    logic [1:0] ioreg_s;
    logic [1:0] xtal_s;
    logic [HBS_WAKE_W-1:0] wake_count;
    logic count_valid;
    logic [HBS_WAKE_W-1:0] remain;
    logic hibernation_unit;
    logic drive;
    hbs_boot_t boot;
    logic [1:0] fidx;
    logic [7:0] trim;
    logic [7:0] pkg;
    logic [7:0] mem;
    logic core_pw;
    logic xtal_en;
    logic cpu_rel;
  } hbs_state_t;
endpackage

// ### hbs_fuse_if.sv
interface hbs_fuse_if;
  import hbs_pkg::*;
  logic wr_en;
  logic wr_all;
  logic [HBS_FUSE_AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [HBS_FUSE_AW-1:0] rd_addr;
  logic [7:0] rd_data;
  modport ctrl (output wr_en, output wr_all, output wr_addr, output wr_data,
                output rd_addr, input rd_data);
  modport array (input wr_en, input wr_all, input wr_addr, input wr_data,
                 input rd_addr, output rd_data);
endinterface

// ### hbs_fuse_array.sv
module hbs_fuse_array
  import hbs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  hbs_fuse_if.array fuse
);
  logic [7:0] cells [HBS_FUSE_BYTES] = '{default: HBS_BYTE_RESET};
  logic [7:0] rd_reg;
  logic [7:0] rd_next;

  always_comb begin
    rd_next = HBS_BYTE_RESET;
    if (fuse.rd_addr <= HBS_FUSE_LAST) begin
      rd_next = cells[fuse.rd_addr];
    end
  end

  // Programming only ever sets bits; a cell is never cleared.
  always_ff @(posedge clk_i) begin
    if (fuse.wr_en) begin
      if (fuse.wr_all) begin
        for (int i = 0; i < HBS_FUSE_BYTES; i++) begin
          cells[i] <= cells[i] | fuse.wr_data;
        end
      end else if (fuse.wr_addr <= HBS_FUSE_LAST) begin
        cells[fuse.wr_addr] <= cells[fuse.wr_addr] | fuse.wr_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_reg <= HBS_BYTE_RESET;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign fuse.rd_data = rd_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  fuse_no_clear_a: assert property (
    fuse.rd_addr == $past(fuse.rd_addr) && $past(fuse.rd_addr) ==
    $past(fuse.rd_addr, 2) |-> (fuse.rd_data & $past(fuse.rd_data)) ==
    $past(fuse.rd_data))
    else $error("A programmed fuse bit returned to zero.");
  fuse_all_cov: cover property (fuse.wr_en && fuse.wr_all);
endmodule // hbs_fuse_array

// ### hbs_sequencer.sv
module hbs_sequencer
  import hbs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic slow_clk_i,
  input wire logic wake_load_i,
  input wire logic [HBS_WAKE_W-1:0] wake_count_i,
  input wire logic hib_request_i,
  input wire logic regulator_enable_i,
  input wire logic hibernation_wake_in_i,
  input wire logic core_regulator_stable_i,
  input wire logic io_regulator_3v3_stable_i,
  input wire logic xtal_ready_i,
  input wire logic fuse_prog_i,
  input wire logic fuse_prog_all_i,
  input wire logic [HBS_FUSE_AW-1:0] fuse_prog_addr_i,
  input wire logic [7:0] fuse_prog_data_i,
  input wire logic [HBS_FUSE_AW-1:0] fuse_rd_addr_i,
  output logic [7:0] fuse_rd_data_o,
  output logic regulator_enable_drive_out_o,
  output logic hibernating_o,
  output logic [7:0] pmu_trim_o,
  output logic [7:0] package_sel_o,
  output logic [7:0] mem_size_sel_o,
  output logic core_power_o,
  output logic xtal_enable_o,
  output logic cpu_release_o
);
  hbs_state_t s_reg;
  hbs_state_t s_next;
  logic slow_edge;
  logic power_req;

  hbs_fuse_if fuse ();

  hbs_fuse_array u_fuse (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .fuse(fuse.array)
  );

  assign slow_edge = s_reg.slow_s[1] & ~s_reg.slow_prev;
  assign power_req = s_reg.regen_s[1] | s_reg.wake_s[1];

  assign fuse.wr_en = fuse_prog_i;
  assign fuse.wr_all = fuse_prog_all_i;
  assign fuse.wr_addr = fuse_prog_addr_i;
  assign fuse.wr_data = fuse_prog_data_i;

  // The boot walk owns the read port while it applies fuse settings.
  always_comb begin
    fuse.rd_addr = fuse_rd_addr_i;
    if (s_reg.boot == HBS_FUSE_INIT) begin
      unique case (s_reg.fidx)
        HBS_FIDX_TRIM: fuse.rd_addr = HBS_FUSE_TRIM_ADDR;
        HBS_FIDX_PKG: fuse.rd_addr = HBS_FUSE_PKG_ADDR;
        HBS_FIDX_MEM: fuse.rd_addr = HBS_FUSE_MEM_ADDR;
        HBS_FIDX_DONE: fuse.rd_addr = fuse_rd_addr_i;
      endcase
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.slow_s = {s_reg.slow_s[0], slow_clk_i};
    s_next.slow_prev = s_reg.slow_s[1];
    s_next.regen_s = {s_reg.regen_s[0], regulator_enable_i};
    s_next.wake_s = {s_reg.wake_s[0], hibernation_wake_in_i};
    s_next.creg_s = {s_reg.creg_s[0], core_regulator_stable_i};
    s_next.ioreg_s = {s_reg.ioreg_s[0], io_regulator_3v3_stable_i};
    s_next.xtal_s = {s_reg.xtal_s[0], xtal_ready_i};

    if (wake_load_i) begin
      s_next.wake_count = wake_count_i;
      s_next.count_valid = (wake_count_i != HBS_COUNT_RESET);
    end

    if (!s_reg.hibernation_unit) begin
      if (hib_request_i && s_reg.count_valid) begin
        s_next.hibernation_unit = 1'b1;
        s_next.drive = 1'b0;
        s_next.remain = s_reg.wake_count;
      end
    end else if (slow_edge) begin
      if (s_reg.remain == HBS_COUNT_ONE) begin
        s_next.hibernation_unit = 1'b0;
        s_next.drive = 1'b1;
        s_next.remain = HBS_COUNT_RESET;
      end else begin
        s_next.remain = s_reg.remain - HBS_COUNT_ONE;
      end
    end

    if (!s_reg.drive || !power_req) begin
      s_next.boot = HBS_IDLE;
      s_next.fidx = HBS_FIDX_TRIM;
      s_next.trim = HBS_BYTE_RESET;
      s_next.pkg = HBS_BYTE_RESET;
      s_next.mem = HBS_BYTE_RESET;
      s_next.core_pw = 1'b0;
      s_next.xtal_en = 1'b0;
      s_next.cpu_rel = 1'b0;
    end else begin
      unique case (s_reg.boot)
        HBS_IDLE: s_next.boot = HBS_REG_WAIT;
        HBS_REG_WAIT: begin
          if (s_reg.creg_s[1] && s_reg.ioreg_s[1]) begin
            s_next.boot = HBS_FUSE_INIT;
            s_next.fidx = HBS_FIDX_TRIM;
          end
        end
        HBS_FUSE_INIT: begin
          // Read data lags the address by one cycle.
          s_next.fidx = s_reg.fidx + 2'h1;
          unique case (s_reg.fidx)
            HBS_FIDX_TRIM: s_next.fidx = HBS_FIDX_PKG;
            HBS_FIDX_PKG: s_next.trim = fuse.rd_data;
            HBS_FIDX_MEM: s_next.pkg = fuse.rd_data;
            HBS_FIDX_DONE: begin
              s_next.mem = fuse.rd_data;
              s_next.boot = HBS_CORE_UP;
            end
          endcase
        end
        HBS_CORE_UP: begin
          s_next.core_pw = 1'b1;
          s_next.boot = HBS_XTAL_WAIT;
        end
        HBS_XTAL_WAIT: begin
          s_next.xtal_en = 1'b1;
          if (s_reg.xtal_en && s_reg.xtal_s[1]) begin
            s_next.boot = HBS_RUN;
            s_next.cpu_rel = 1'b1;
          end
        end
        HBS_RUN: s_next.boot = HBS_RUN;
        default: s_next.boot = HBS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_reg <= '0;
      s_reg.drive <= 1'b1;
      s_reg.boot <= HBS_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign fuse_rd_data_o = fuse.rd_data;
  assign regulator_enable_drive_out_o = s_reg.drive;
  assign hibernating_o = s_reg.hibernation_unit;
  assign pmu_trim_o = s_reg.trim;
  assign package_sel_o = s_reg.pkg;
  assign mem_size_sel_o = s_reg.mem;
  assign core_power_o = s_reg.core_pw;
  assign xtal_enable_o = s_reg.xtal_en;
  assign cpu_release_o = s_reg.cpu_rel;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  hib_entry_low_a: assert property (
    !s_reg.hibernation_unit && hib_request_i && s_reg.count_valid |=>
    !regulator_enable_drive_out_o && s_reg.remain == $past(s_reg.wake_count))
    else $error("Hibernation entry did not drop the drive.");
  hib_hold_low_a: assert property (
    s_reg.hibernation_unit |-> !regulator_enable_drive_out_o)
    else $error("Drive rose while hibernating.");
  timer_expiry_a: assert property (
    s_reg.hibernation_unit && slow_edge && s_reg.remain == 16'h0001 |=>
    regulator_enable_drive_out_o && !s_reg.hibernation_unit)
    else $error("Drive not restored at expiry.");
  timer_step_a: assert property (
    s_reg.hibernation_unit && slow_edge && s_reg.remain > 16'h0001 |=>
    s_reg.remain == $past(s_reg.remain) - 16'h0001 && s_reg.hibernation_unit)
    else $error("Wake timer did not step by one.");
  no_count_hib_a: assert property (
    !s_reg.hibernation_unit && !s_reg.count_valid |=> !s_reg.hibernation_unit)
    else $error("Hibernation entered without a wake count.");
  boot_lost_a: assert property (
    !regulator_enable_drive_out_o |=> s_reg.boot == HBS_IDLE && !core_power_o)
    else $error("Boot state survived hibernation.");
  boot_start_a: assert property (
    s_reg.boot == HBS_IDLE && power_req && s_reg.drive |=>
    s_reg.boot == HBS_REG_WAIT)
    else $error("Boot did not start.");
  reg_wait_a: assert property (
    s_reg.boot == HBS_REG_WAIT && !(s_reg.creg_s[1] && s_reg.ioreg_s[1]) |=>
    s_reg.boot != HBS_FUSE_INIT)
    else $error("Left regulator wait early.");
  fuse_before_core_a: assert property (
    $rose(core_power_o) |-> $past(s_reg.boot, 2) == HBS_FUSE_INIT)
    else $error("Cores powered before fuse setup.");
  xtal_order_a: assert property (
    xtal_enable_o |-> core_power_o)
    else $error("Crystal enabled before core power.");
  release_order_a: assert property (
    cpu_release_o |-> xtal_enable_o && $past(xtal_enable_o))
    else $error("Processors released before crystal.");
  core_after_fuse_a: assert property (
    s_reg.boot == HBS_CORE_UP && s_reg.drive && power_req |=> core_power_o)
    else $error("Core domains not powered after fuse setup.");

  hib_done_cov: cover property (s_reg.hibernation_unit ##1 !s_reg.hibernation_unit);
  boot_run_cov: cover property (s_reg.boot == HBS_RUN);
  wake_boot_cov: cover property (s_reg.wake_s[1] && s_reg.boot == HBS_REG_WAIT);
endmodule // hbs_sequencer

// ### hbs_power_model.sv
module hbs_power_model (
  input wire logic clk_i,
  input wire logic main_power_i,
  input wire logic wake_i,
  input wire logic drive_out_i,
  input wire logic xtal_enable_i,
  input wire logic slow_i,
  output logic regulator_enable_o,
  output logic core_stable_o,
  output logic io_stable_o,
  output logic xtal_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int rail_cnt = 0;
  int xtal_cnt = 0;
  // The regulator input is the drive output of the timer ANDed with main power.
  assign regulator_enable_o = main_power_i & drive_out_i;
  always_ff @(posedge clk_i) begin
    rail_cnt <= (regulator_enable_o | wake_i) ? rail_cnt + 1 : 0;
    xtal_cnt <= xtal_enable_i ? xtal_cnt + 1 : 0;
  end
  // The slow variant makes the rails and the crystal settle much later.
  assign core_stable_o = rail_cnt > (slow_i ? 20 : 2);
  assign io_stable_o = rail_cnt > (slow_i ? 30 : 3);
  assign xtal_ready_o = xtal_cnt > (slow_i ? 40 : 1);
endmodule // hbs_power_model

// ### testbench.sv
module testbench
  import hbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic slow_clk_i = 1'b0, wake_load_i = 1'b0, hib_request_i = 1'b0;
  logic [HBS_WAKE_W-1:0] wake_count_i = '0;
  logic hibernation_wake_in_i = 1'b0, main_power = 1'b0, slow_model = 1'b0;
  logic fuse_prog_i = 1'b0, fuse_prog_all_i = 1'b0;
  logic [HBS_FUSE_AW-1:0] fuse_prog_addr_i = '0, fuse_rd_addr_i = '0;
  logic [7:0] fuse_prog_data_i = 8'h00;
  logic regulator_enable_i, core_regulator_stable_i;
  logic io_regulator_3v3_stable_i, xtal_ready_i;
  logic [7:0] fuse_rd_data_o, pmu_trim_o, package_sel_o, mem_size_sel_o;
  logic regulator_enable_drive_out_o, hibernating_o, core_power_o;
  logic xtal_enable_o, cpu_release_o;
  int failures = 0;
  int check_count = 0;

  hbs_sequencer dut (.clk_i(clk_i), .reset_i(reset_i),
    .slow_clk_i(slow_clk_i), .wake_load_i(wake_load_i),
    .wake_count_i(wake_count_i), .hib_request_i(hib_request_i),
    .regulator_enable_i(regulator_enable_i),
    .hibernation_wake_in_i(hibernation_wake_in_i),
    .core_regulator_stable_i(core_regulator_stable_i),
    .io_regulator_3v3_stable_i(io_regulator_3v3_stable_i),
    .xtal_ready_i(xtal_ready_i), .fuse_prog_i(fuse_prog_i),
    .fuse_prog_all_i(fuse_prog_all_i), .fuse_prog_addr_i(fuse_prog_addr_i),
    .fuse_prog_data_i(fuse_prog_data_i), .fuse_rd_addr_i(fuse_rd_addr_i),
    .fuse_rd_data_o(fuse_rd_data_o),
    .regulator_enable_drive_out_o(regulator_enable_drive_out_o),
    .hibernating_o(hibernating_o), .pmu_trim_o(pmu_trim_o),
    .package_sel_o(package_sel_o), .mem_size_sel_o(mem_size_sel_o),
    .core_power_o(core_power_o), .xtal_enable_o(xtal_enable_o),
    .cpu_release_o(cpu_release_o));

  hbs_power_model power (.clk_i(clk_i), .main_power_i(main_power),
    .wake_i(hibernation_wake_in_i),
    .drive_out_i(regulator_enable_drive_out_o),
    .xtal_enable_i(xtal_enable_o), .slow_i(slow_model),
    .regulator_enable_o(regulator_enable_i),
    .core_stable_o(core_regulator_stable_i),
    .io_stable_o(io_regulator_3v3_stable_i), .xtal_ready_o(xtal_ready_i));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask

  task automatic check8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic pick(input int k);
    logic [3:0] v;
    v = {regulator_enable_drive_out_o, cpu_release_o, xtal_enable_o,
         core_power_o};
    return v[k];
  endfunction

  // Waits a bounded number of cycles for an output to reach a level.
  task automatic wait_lvl(input int k, input logic lvl, input int lim,
                          output int n);
    n = 0;
    while (pick(k) !== lvl && n < lim) begin
      tick(1);
      n++;
    end
    check8("output level", {7'h00, lvl}, {7'h00, pick(k)});
  endtask

  task automatic prog(input logic all, input logic [9:0] a,
                      input logic [7:0] d);
    fuse_prog_i = 1'b1;
    fuse_prog_all_i = all;
    fuse_prog_addr_i = a;
    fuse_prog_data_i = d;
    tick(1);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    fuse_prog_i = 1'b0;
    fuse_rd_addr_i = a;
    tick(2);
    check8("fuse byte", exp, fuse_rd_data_o);
  endtask

  task automatic s_reset;
    check8("drive", 8'h01, {7'h00, regulator_enable_drive_out_o});
    check8("hib", 8'h00, {7'h00, hibernating_o});
    check8("core", 8'h00, {7'h00, core_power_o});
    rd(10'h005, 8'h00);
  endtask

  task automatic s_refuse;
    hib_request_i = 1'b1;
    tick(1);
    wake_load_i = 1'b1;
    tick(1);
    wake_load_i = 1'b0;
    tick(2);
    hib_request_i = 1'b0;
    check8("refused", 8'h01, {7'h00, regulator_enable_drive_out_o});
  endtask

  task automatic s_fuse;
    prog(1'b0, 10'h005, 8'h0F);
    prog(1'b0, 10'h005, 8'hF0);
    rd(10'h005, 8'hFF);
    prog(1'b0, 10'h005, 8'h00);
    rd(10'h005, 8'hFF);
    prog(1'b1, 10'h000, 8'h01);
    prog(1'b0, 10'h300, 8'hFF);
    rd(HBS_FUSE_LAST, 8'h01);
    rd(10'h300, 8'h00);
    prog(1'b0, 10'h000, 8'hA4);
    prog(1'b0, 10'h001, 8'h3C);
    prog(1'b0, 10'h002, 8'h80);
    rd(10'h001, 8'h3D);
  endtask

  task automatic s_boot(input logic by_wake, input int min_n);
    int n;
    slow_model = by_wake;
    if (by_wake) hibernation_wake_in_i = 1'b1;
    else main_power = 1'b1;
    wait_lvl(0, 1'b1, 200, n);
    check8("rails", 8'h01, {7'h00, n >= min_n});
    check8("trim", 8'hA5, pmu_trim_o);
    check8("package", 8'h3D, package_sel_o);
    check8("memory", 8'h81, mem_size_sel_o);
    check8("early xtal", 8'h00, {7'h00, xtal_enable_o});
    wait_lvl(1, 1'b1, 5, n);
    check8("core", 8'h01, {7'h00, core_power_o});
    check8("early cpu", 8'h00, {7'h00, cpu_release_o});
    wait_lvl(2, 1'b1, 100, n);
    check8("cpu wait", 8'h01, {7'h00, n >= min_n});
  endtask

  task automatic s_off;
    int n;
    main_power = 1'b0;
    hibernation_wake_in_i = 1'b0;
    wait_lvl(0, 1'b0, 10, n);
    check8("cpu off", 8'h00, {7'h00, cpu_release_o});
  endtask

  task automatic s_hib(input logic load, input int cnt);
    int k;
    if (load) begin
      wake_load_i = 1'b1;
      wake_count_i = cnt[HBS_WAKE_W-1:0];
      tick(1);
      wake_load_i = 1'b0;
    end
    hib_request_i = 1'b1;
    tick(1);
    hib_request_i = 1'b0;
    check8("drive", 8'h00, {7'h00, regulator_enable_drive_out_o});
    check8("hib", 8'h01, {7'h00, hibernating_o});
    wait_lvl(0, 1'b0, 10, k);
    for (int i = 1; i <= cnt; i++) begin
      slow_clk_i = 1'b1;
      tick(2);
      check8("drive", 8'h00, {7'h00, regulator_enable_drive_out_o});
      if (i == cnt) wait_lvl(3, 1'b1, 6, k);
      tick(310 - k);
      slow_clk_i = 1'b0;
      tick(313);
    end
    check8("hib", 8'h00, {7'h00, hibernating_o});
    wait_lvl(0, 1'b1, 200, k);
  endtask

  task automatic results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #1000000;
    failures++;
    results;
  end

  initial begin
    repeat (3) @(posedge clk_i);
    #5 reset_i = 1'b0;
    s_reset;
    s_refuse;
    s_fuse;
    s_boot(1'b0, 0);
    s_off;
    s_boot(1'b1, 31);
    s_off;
    s_boot(1'b0, 0);
    s_hib(1'b1, 3);
    s_hib(1'b1, 1);
    s_hib(1'b0, 1);
    results;
  end
endmodule // testbench
